/* File: design/ait_pkg.sv */
// Package for the arithmetic execute and timing unit.
// Assumes one core state clock; all sizes fixed.
package ait_pkg;

    // Operation codes
    typedef enum logic [2:0]
    {
        AIT_OP_SUM = 3'h0,
        AIT_OP_DIFF = 3'h1,
        AIT_OP_CARRY_SUM = 3'h2,
        AIT_OP_BORROW_DIFF = 3'h3,
        AIT_OP_STEP_UP = 3'h4,
        AIT_OP_STEP_DOWN = 3'h5,
        AIT_OP_COMPARE = 3'h6
    } ait_op_type;

    // Operand forms
    typedef enum logic [3:0]
    {
        AIT_F_ACC_BANK = 4'h0,
        AIT_F_ACC_DIRECT_8BIT_OPERAND = 4'h1,
        AIT_F_ACC_PTR = 4'h2,
        AIT_F_ACC_IMM = 4'h3,
        AIT_F_BYTE_BYTE = 4'h4,
        AIT_F_WORD_WORD = 4'h5,
        AIT_F_DWORD_DWORD = 4'h6,
        AIT_F_DWORD_IMM0 = 4'h7,
        AIT_F_DWORD_IMM1 = 4'h8,
        AIT_F_WORD_IMM16 = 4'h9,
        AIT_F_WORD_DIRECT_16BIT_OPERAND = 4'ha,
        AIT_F_BYTE_DIRECT_16BIT_OPERAND = 4'hb,
        AIT_F_BYTE_IND_DWORD = 4'hc,
        AIT_F_STEP_DIRECT_8BIT_OPERAND = 4'hd,
        AIT_F_STEP_PTR = 4'he,
        AIT_F_STEP_SHORT = 4'hf
    } ait_form_type;

    // Operand sizes
    typedef enum logic [1:0]
    {
        AIT_SZ_BYTE = 2'h0,
        AIT_SZ_WORD = 2'h1,
        AIT_SZ_DWORD = 2'h2
    } ait_size_type;

    // Operand location for extra states
    typedef enum logic [1:0]
    {
        AIT_LOC_PLAIN = 2'h0,
        AIT_LOC_IO_PORT = 2'h1,
        AIT_LOC_PERIPH = 2'h2,
        AIT_LOC_EXTERNAL = 2'h3
    } ait_loc_type;

    localparam logic [7:0] AIT_EXTRA_IO = 8'h01;
    localparam logic [7:0] AIT_EXTRA_PERIPH = 8'h02;
    localparam logic [7:0] AIT_EXTRA_STEP_IO = 8'h02;
    localparam logic [7:0] AIT_EXTRA_STEP_PERIPH = 8'h03;
    localparam logic [7:0] AIT_EXT_BASE = 8'h02;
    localparam logic [15:0] AIT_ONES_WORD = 16'hffff;
    localparam logic [31:0] AIT_RESULT_RESET = 32'h0000_0000;

endpackage

/* File: design/ait_unit.sv */
// Arithmetic execute and timing unit: result, flags, length and states.
// Assumes operands are fetched by the core; one request per start pulse.
// Operation
// RL1 - Sum writes destination plus source, byte word or dword.
// RL2 - Difference writes destination minus source.
// RL3 - Carry-sum writes accumulator plus source plus carry flag.
// RL4 - Borrow-difference writes accumulator minus source minus carry flag.
// RL5 - Accumulator with bank byte: 1 byte 1 state; source 2 and 2.
// RL6 - Accumulator pointer-indirect: 1 byte 2 states; source 2 bytes 3 states.
// RL7 - Byte register pair: 3 bytes 2 states; source 2 bytes 1 state.
// RL8 - Word register pair: 3 bytes 3 states; source 2 bytes 2 states.
// RL9 - Dword register pair: 3 bytes 5 states; source 2 bytes 4 states.
// RL10 - Dword with zero-extended immediate: 5/6 binary, 4/5 source.
// RL11 - Word with 16-bit immediate: 5/4 binary, 4/3 source.
// RL12 - Word with 16-bit direct memory: 5/4 binary, 4/3 source.
// RL13 - Marked forms: add 1 state for I/O port, 2 for peripheral.
// RL14 - Byte forms reaching external memory add N+2 states.
// RL15 - Word forms reaching external memory add twice N+2 states.
// RL16 - Step on direct operand: add 2 for I/O, 3 for peripheral.
// RL17 - Step of direct location by one: 2 bytes 2 states both modes.
// RL18 - Step via pointer byte: 1 byte 3 states; source 2 and 4.
// RL19 - Short step accepts 1, 2, 4 only; 3/2 binary, 2/1 source.
// RL20 - Short dword step up 4 states, down 5; source one fewer.
// RL21 - Dword compare with one-extended immediate: 5/6 binary, 4/5 source.
// RL22 - Byte compare via dword pointer: 4/4 binary, 3/3 source.
// RL23 - One-extended immediate fills ones above, zero-extended fills zeros.
// RL24 - Compare only updates flags, destination left unchanged.
`timescale 1ns/1ps
module ait_unit
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request
    input wire logic start,
    input wire ait_pkg::ait_op_type op,
    input wire ait_pkg::ait_form_type form,
    input wire ait_pkg::ait_size_type size,
    input wire ait_pkg::ait_loc_type loc,
    input wire logic sourceMode,
    input wire logic [3:0] waitStates,
    input wire logic [31:0] destOperand,
    input wire logic [31:0] srcOperand,
    input wire logic [2:0] shortStep,
    input wire logic carryIn,
    // Answer
    output logic done,
    output logic writeBack,
    output logic illegal,
    output logic [31:0] result,
    output logic carryOut,
    output logic zeroOut,
    output logic [2:0] instrBytes,
    output logic [7:0] instrStates
);
    import ait_pkg::*;

    typedef struct packed
    {
        logic done;
        logic writeBack;
        logic illegal;
        logic [31:0] result;
        logic carryOut;
        logic zeroOut;
        logic [2:0] instrBytes;
        logic [7:0] instrStates;
    } ait_state_type;

    ait_state_type state_r;
    ait_state_type state_nxt;

    logic [31:0] srcExt;
    logic [32:0] wide;
    logic [31:0] sizeMask;
    logic [2:0] bytesB;
    logic [2:0] bytesS;
    logic [7:0] baseB;
    logic [7:0] baseS;
    logic [7:0] extra;
    logic [7:0] extUnit;
    logic shortOk;
    logic subtract;
    logic carryBit;

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.done = 1'b0;
        state_nxt.writeBack = 1'b0;
        srcExt = srcOperand;
        sizeMask = 32'h0000_00ff;
        bytesB = 3'h3;
        bytesS = 3'h2;
        baseB = 8'h02;
        baseS = 8'h01;
        extra = 8'h00;
        extUnit = AIT_EXT_BASE + {4'h0, waitStates};
        shortOk = (shortStep == 3'h1) || (shortStep == 3'h2) || (shortStep == 3'h4);
        subtract = 1'b0;
        carryBit = 1'b0;
        wide = 33'h0;
        unique case (size)
            AIT_SZ_BYTE: sizeMask = 32'h0000_00ff;
            AIT_SZ_WORD: sizeMask = 32'h0000_ffff;
            AIT_SZ_DWORD: sizeMask = 32'hffff_ffff;
            default: sizeMask = 32'h0000_00ff;
        endcase
        // RL23 immediate upper fill
        if (form == AIT_F_DWORD_IMM1)
            srcExt = {AIT_ONES_WORD, srcOperand[15:0]};
        else if (form == AIT_F_DWORD_IMM0)
            srcExt = {16'h0000, srcOperand[15:0]};
        else if (op == AIT_OP_STEP_UP || op == AIT_OP_STEP_DOWN)
            srcExt = (form == AIT_F_STEP_SHORT) ? {29'h0, shortStep} : 32'h1;
        // Length and base states per form
        unique case (form)
            // RL5 bank byte timing
            AIT_F_ACC_BANK:
            begin
                bytesB = 3'h1;
                baseB = 8'h01;
                bytesS = 3'h2;
                baseS = 8'h02;
            end
            AIT_F_ACC_DIRECT_8BIT_OPERAND:
            begin
                bytesB = 3'h2;
                baseB = 8'h01;
                bytesS = 3'h2;
                baseS = 8'h01;
            end
            // RL6 pointer indirect timing
            AIT_F_ACC_PTR:
            begin
                bytesB = 3'h1;
                baseB = 8'h02;
                bytesS = 3'h2;
                baseS = 8'h03;
            end
            AIT_F_ACC_IMM:
            begin
                bytesB = 3'h2;
                baseB = 8'h01;
                bytesS = 3'h2;
                baseS = 8'h01;
            end
            // RL7 byte pair timing
            AIT_F_BYTE_BYTE:
            begin
                bytesB = 3'h3;
                baseB = 8'h02;
                bytesS = 3'h2;
                baseS = 8'h01;
            end
            // RL8 word pair timing
            AIT_F_WORD_WORD:
            begin
                bytesB = 3'h3;
                baseB = 8'h03;
                bytesS = 3'h2;
                baseS = 8'h02;
            end
            // RL9 dword pair timing
            AIT_F_DWORD_DWORD:
            begin
                bytesB = 3'h3;
                baseB = 8'h05;
                bytesS = 3'h2;
                baseS = 8'h04;
            end
            // RL10 RL21 extended immediate timing
            AIT_F_DWORD_IMM0, AIT_F_DWORD_IMM1:
            begin
                bytesB = 3'h5;
                baseB = 8'h06;
                bytesS = 3'h4;
                baseS = 8'h05;
            end
            // RL11 RL12 word immediate or direct
            AIT_F_WORD_IMM16, AIT_F_WORD_DIRECT_16BIT_OPERAND:
            begin
                bytesB = 3'h5;
                baseB = 8'h04;
                bytesS = 3'h4;
                baseS = 8'h03;
            end
            AIT_F_BYTE_DIRECT_16BIT_OPERAND:
            begin
                bytesB = 3'h5;
                baseB = 8'h03;
                bytesS = 3'h4;
                baseS = 8'h02;
            end
            // RL22 dword pointer compare
            AIT_F_BYTE_IND_DWORD:
            begin
                bytesB = 3'h4;
                baseB = 8'h04;
                bytesS = 3'h3;
                baseS = 8'h03;
            end
            // RL17 direct step
            AIT_F_STEP_DIRECT_8BIT_OPERAND:
            begin
                bytesB = 3'h2;
                baseB = 8'h02;
                bytesS = 3'h2;
                baseS = 8'h02;
            end
            // RL18 pointer step
            AIT_F_STEP_PTR:
            begin
                bytesB = 3'h1;
                baseB = 8'h03;
                bytesS = 3'h2;
                baseS = 8'h04;
            end
            // RL19 RL20 short step
            AIT_F_STEP_SHORT:
            begin
                bytesB = 3'h3;
                bytesS = 3'h2;
                baseB = 8'h02;
                baseS = 8'h01;
                if (size == AIT_SZ_DWORD)
                begin
                    baseB = (op == AIT_OP_STEP_DOWN) ? 8'h05 : 8'h04;
                    baseS = (op == AIT_OP_STEP_DOWN) ? 8'h04 : 8'h03;
                end
            end
        endcase
        // RL13 RL16 extra states for ports and peripherals
        if (form == AIT_F_ACC_DIRECT_8BIT_OPERAND || form == AIT_F_STEP_DIRECT_8BIT_OPERAND)
        begin
            if (loc == AIT_LOC_IO_PORT)
                extra = (form == AIT_F_STEP_DIRECT_8BIT_OPERAND) ? AIT_EXTRA_STEP_IO : AIT_EXTRA_IO;
            else if (loc == AIT_LOC_PERIPH)
                extra = (form == AIT_F_STEP_DIRECT_8BIT_OPERAND) ? AIT_EXTRA_STEP_PERIPH : AIT_EXTRA_PERIPH;
        end
        // RL14 RL15 external memory wait states
        if (loc == AIT_LOC_EXTERNAL)
        begin
            if (form == AIT_F_WORD_DIRECT_16BIT_OPERAND)
                extra = {extUnit[6:0], 1'b0};
            else if (form == AIT_F_BYTE_DIRECT_16BIT_OPERAND || form == AIT_F_BYTE_IND_DWORD)
                extra = extUnit;
        end
        // RL1 RL2 RL3 RL4 arithmetic
        subtract = (op == AIT_OP_DIFF) || (op == AIT_OP_BORROW_DIFF) ||
            (op == AIT_OP_STEP_DOWN) || (op == AIT_OP_COMPARE);
        carryBit = ((op == AIT_OP_CARRY_SUM) || (op == AIT_OP_BORROW_DIFF)) && carryIn;
        if (subtract)
            wide = {1'b0, destOperand & sizeMask} - {1'b0, srcExt & sizeMask} -
                {32'h0, carryBit};
        else
            wide = {1'b0, destOperand & sizeMask} + {1'b0, srcExt & sizeMask} +
                {32'h0, carryBit};
        if (start)
        begin
            state_nxt.done = 1'b1;
            // RL19 short step legality
            state_nxt.illegal = (form == AIT_F_STEP_SHORT) && !shortOk;
            state_nxt.instrBytes = sourceMode ? bytesS : bytesB;
            state_nxt.instrStates = (sourceMode ? baseS : baseB) + extra;
            if (!state_nxt.illegal)
            begin
                state_nxt.result = wide[31:0] & sizeMask;
                unique case (size)
                    AIT_SZ_WORD: state_nxt.carryOut = wide[16];
                    AIT_SZ_DWORD: state_nxt.carryOut = wide[32];
                    default: state_nxt.carryOut = wide[8];
                endcase
                state_nxt.zeroOut = ((wide[31:0] & sizeMask) == 32'h0);
                // RL24 compare keeps destination
                state_nxt.writeBack = (op != AIT_OP_COMPARE);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= '0;
            state_r.result <= AIT_RESULT_RESET;
        end
        else
            state_r <= state_nxt;
    end

    assign done = state_r.done;
    assign writeBack = state_r.writeBack;
    assign illegal = state_r.illegal;
    assign result = state_r.result;
    assign carryOut = state_r.carryOut;
    assign zeroOut = state_r.zeroOut;
    assign instrBytes = state_r.instrBytes;
    assign instrStates = state_r.instrStates;

    property p_sum_result;
        @(posedge clk) disable iff (!rst_b)
        start && op == AIT_OP_SUM && size == AIT_SZ_DWORD && form == AIT_F_DWORD_DWORD
        |=> result == $past(destOperand) + $past(srcOperand);
    endproperty
    a_sum_result: assert property (p_sum_result) else $error("sum result wrong"); // RL1

    property p_diff_byte;
        @(posedge clk) disable iff (!rst_b)
        start && op == AIT_OP_DIFF && size == AIT_SZ_BYTE && form == AIT_F_BYTE_BYTE
        |=> result[7:0] == 8'($past(destOperand[7:0]) - $past(srcOperand[7:0]));
    endproperty
    a_diff_byte: assert property (p_diff_byte) else $error("difference result wrong"); // RL2

    property p_carry_sum;
        @(posedge clk) disable iff (!rst_b)
        start && op == AIT_OP_CARRY_SUM && size == AIT_SZ_BYTE
        |=> result[7:0] == 8'($past(destOperand[7:0]) + $past(srcOperand[7:0])
            + {7'h0, $past(carryIn)});
    endproperty
    a_carry_sum: assert property (p_carry_sum) else $error("carry sum wrong"); // RL3

    property p_borrow_diff;
        @(posedge clk) disable iff (!rst_b)
        start && op == AIT_OP_BORROW_DIFF && size == AIT_SZ_BYTE
        |=> result[7:0] == 8'($past(destOperand[7:0]) - $past(srcOperand[7:0])
            - {7'h0, $past(carryIn)});
    endproperty
    a_borrow_diff: assert property (p_borrow_diff) else $error("borrow difference wrong"); // RL4

    property p_bank_timing;
        @(posedge clk) disable iff (!rst_b)
        start && form == AIT_F_ACC_BANK
        |=> instrStates == ($past(sourceMode) ? 8'h02 : 8'h01) && done;
    endproperty
    a_bank_timing: assert property (p_bank_timing) else $error("bank form states wrong"); // RL5

    property p_dword_pair;
        @(posedge clk) disable iff (!rst_b)
        start && form == AIT_F_DWORD_DWORD && !sourceMode
        |=> instrBytes == 3'h3 && instrStates == 8'h05;
    endproperty
    a_dword_pair: assert property (p_dword_pair) else $error("dword pair timing wrong"); // RL9

    property p_ext_word;
        @(posedge clk) disable iff (!rst_b)
        start && form == AIT_F_WORD_DIRECT_16BIT_OPERAND && loc == AIT_LOC_EXTERNAL && sourceMode
        |=> instrStates == 8'h03 + 8'h2 * (8'h02 + {4'h0, $past(waitStates)});
    endproperty
    a_ext_word: assert property (p_ext_word) else $error("external word states wrong"); // RL15

    property p_short_illegal;
        @(posedge clk) disable iff (!rst_b)
        start && form == AIT_F_STEP_SHORT && shortStep == 3'h3
        |=> illegal && !writeBack;
    endproperty
    a_short_illegal: assert property (p_short_illegal) else $error("bad step accepted"); // RL19

    property p_compare_keep;
        @(posedge clk) disable iff (!rst_b)
        start && op == AIT_OP_COMPARE |=> done && !writeBack;
    endproperty
    a_compare_keep: assert property (p_compare_keep) else $error("compare wrote back"); // RL24

endmodule

/* File: tb/test_arith_instr_size_timing.sv */
// Self-checking bench for the arithmetic execute and timing unit.
// Assumes ait_pkg and ait_unit are compiled first; inputs driven at posedge.
`timescale 1ns/1ps
module test_arith_instr_size_timing;
    import ait_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    ait_op_type op = AIT_OP_SUM;
    ait_form_type form = AIT_F_ACC_BANK;
    ait_size_type size = AIT_SZ_BYTE;
    ait_loc_type loc = AIT_LOC_PLAIN;
    logic sourceMode = 1'b0;
    logic [3:0] waitStates = 4'h0;
    logic [31:0] destOperand = 32'h0;
    logic [31:0] srcOperand = 32'h0;
    logic [2:0] shortStep = 3'h1;
    logic carryIn = 1'b0;
    logic done, writeBack, illegal, carryOut, zeroOut;
    logic [31:0] result;
    logic [2:0] instrBytes;
    logic [7:0] instrStates;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] lfsr = 16'h2a5e;
    logic [15:0] lenTab [16] = '{16'h1122, 16'h2121, 16'h1223, 16'h2121, 16'h3221, 16'h3322,
        16'h3524, 16'h5645, 16'h5645, 16'h5443, 16'h5443, 16'h5342, 16'h4433, 16'h2222,
        16'h1324, 16'h3221};
    // Expected outputs, and the staged answer of the request in flight
    logic pend = 1'b0;
    logic eDone = 1'b0, eWb = 1'b0, eIll = 1'b0, eCy = 1'b0, eZ = 1'b0;
    logic resK = 1'b1, lenK = 1'b1, flK = 1'b1;
    logic [31:0] eRes = 32'h0, sRes;
    logic [7:0] eB = 8'h0, eSt = 8'h0, sB, sSt;
    logic sIll, sWb, sCy, sZ, sResK, sFlK;

    ait_unit dut (.clk(clk), .rst_b(rst_b), .start(start), .op(op), .form(form), .size(size),
        .loc(loc), .sourceMode(sourceMode), .waitStates(waitStates), .destOperand(destOperand),
        .srcOperand(srcOperand), .shortStep(shortStep), .carryIn(carryIn), .done(done),
        .writeBack(writeBack), .illegal(illegal), .result(result), .carryOut(carryOut),
        .zeroOut(zeroOut), .instrBytes(instrBytes), .instrStates(instrStates));

    always #50 clk = ~clk;

    function automatic logic [15:0] rnd();
        lfsr = lfsr[0] ? ((lfsr >> 1) ^ 16'hb400) : (lfsr >> 1);
        return lfsr;
    endfunction

    function automatic logic [31:0] rnd32();
        logic [1:0] k;
        k = rnd() % 4;
        // Bias toward carry and zero boundaries
        return (k == 0) ? 32'h0 : (k == 1) ? 32'hffff_ffff : {rnd(), rnd()};
    endfunction

    function automatic ait_size_type sizeOf(input ait_form_type f, input int r);
        if (f == AIT_F_WORD_WORD || f == AIT_F_WORD_IMM16 || f == AIT_F_WORD_DIRECT_16BIT_OPERAND)
            return AIT_SZ_WORD;
        if (f == AIT_F_DWORD_DWORD || f == AIT_F_DWORD_IMM0 || f == AIT_F_DWORD_IMM1)
            return AIT_SZ_DWORD;
        return (f == AIT_F_STEP_SHORT) ? ait_size_type'(r % 3) : AIT_SZ_BYTE;
    endfunction

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic step(input logic go, input ait_op_type o, input ait_form_type f,
        input ait_size_type sz, input ait_loc_type l, input logic sm, input logic [3:0] ws,
        input logic [31:0] d, input logic [31:0] s, input logic [2:0] ss, input logic c);
        int w;
        longint m, sv, full;
        logic [15:0] t;
        @(posedge clk);
        eDone = pend;
        eWb = pend & sWb;
        if (pend)
        begin
            eIll = sIll;
            lenK = !sIll;
            eB = sB;
            eSt = sSt;
            if (!sIll)
            begin
                resK = sResK;
                eRes = sResK ? sRes : eRes;
                flK = sFlK;
                eCy = sCy;
                eZ = sZ;
            end
        end
        start <= go;
        op <= o;
        form <= f;
        size <= sz;
        loc <= l;
        sourceMode <= sm;
        waitStates <= ws;
        destOperand <= d;
        srcOperand <= s;
        shortStep <= ss;
        carryIn <= c;
        pend = go;
        w = (sz == AIT_SZ_BYTE) ? 8 : (sz == AIT_SZ_WORD) ? 16 : 32;
        m = (64'h1 << w) - 1;
        sv = s;
        // Upper word filled with zeros or ones
        if (f == AIT_F_DWORD_IMM0) sv = {16'h0000, s[15:0]};
        if (f == AIT_F_DWORD_IMM1) sv = {16'hffff, s[15:0]};
        if (o == AIT_OP_STEP_UP || o == AIT_OP_STEP_DOWN) sv = (f == AIT_F_STEP_SHORT) ? ss : 1;
        sv = sv & m;
        full = d & m;
        if (o == AIT_OP_SUM || o == AIT_OP_STEP_UP || o == AIT_OP_CARRY_SUM) full = full + sv;
        else full = full - sv;
        if (o == AIT_OP_CARRY_SUM) full = full + c;
        if (o == AIT_OP_BORROW_DIFF) full = full - c;
        sRes = full & m;
        sCy = full[w];
        sZ = (sRes == 0);
        sIll = (f == AIT_F_STEP_SHORT) && !(ss == 1 || ss == 2 || ss == 4);
        sWb = !sIll && (o != AIT_OP_COMPARE);
        sResK = (o != AIT_OP_COMPARE);
        sFlK = (o != AIT_OP_STEP_UP && o != AIT_OP_STEP_DOWN);
        t = lenTab[f];
        sB = sm ? t[7:4] : t[15:12];
        sSt = sm ? t[3:0] : t[11:8];
        if (f == AIT_F_STEP_SHORT && sz == AIT_SZ_DWORD)
            sSt = ((o == AIT_OP_STEP_DOWN) ? 8'h05 : 8'h04) - sm;
        if (f == AIT_F_ACC_DIRECT_8BIT_OPERAND && l == AIT_LOC_IO_PORT) sSt = sSt + 1;
        if (f == AIT_F_ACC_DIRECT_8BIT_OPERAND && l == AIT_LOC_PERIPH) sSt = sSt + 2;
        if (f == AIT_F_STEP_DIRECT_8BIT_OPERAND && l == AIT_LOC_IO_PORT) sSt = sSt + 2;
        if (f == AIT_F_STEP_DIRECT_8BIT_OPERAND && l == AIT_LOC_PERIPH) sSt = sSt + 3;
        if ((f == AIT_F_BYTE_DIRECT_16BIT_OPERAND || f == AIT_F_BYTE_IND_DWORD) && l == AIT_LOC_EXTERNAL)
            sSt = sSt + ws + 2;
        if (f == AIT_F_WORD_DIRECT_16BIT_OPERAND && l == AIT_LOC_EXTERNAL) sSt = sSt + 2 * (ws + 2);
        @(negedge clk);
        chk("done", eDone, done);
        chk("writeBack", eWb, writeBack);
        chk("illegal", eIll, illegal);
        if (resK) chk("result", eRes, result);
        if (flK) chk("carryOut", eCy, carryOut);
        if (flK) chk("zeroOut", eZ, zeroOut);
        if (lenK) chk("instrBytes", eB, instrBytes);
        if (lenK) chk("instrStates", eSt, instrStates);
    endtask

    task automatic rstep();
        ait_op_type o;
        ait_form_type f;
        int k;
        logic [2:0] ss;
        o = ait_op_type'(rnd() % 7);
        k = rnd();
        if (o == AIT_OP_CARRY_SUM || o == AIT_OP_BORROW_DIFF) f = ait_form_type'(k % 4);
        else if (o == AIT_OP_COMPARE) f = ait_form_type'(4 + k % 9);
        else if (o == AIT_OP_STEP_UP || o == AIT_OP_STEP_DOWN) f = ait_form_type'(13 + k % 3);
        else f = ait_form_type'((k % 12 < 8) ? k % 12 : k % 12 + 1);
        ss = 3'h1 << (rnd() % 3);
        step(1'b1, o, f, sizeOf(f, rnd()), ait_loc_type'(rnd() % 4), rnd() % 2, rnd() % 16,
            rnd32(), rnd32(), ss, rnd() % 2);
        if (rnd() % 4 == 0) step(1'b0, o, f, size, loc, 0, 0, 0, 0, 1, 0);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            num_errors++;
            final_report();
        end
    end

    initial
    begin
        ait_form_type fl [5];
        ait_op_type o;
        fl = '{AIT_F_ACC_DIRECT_8BIT_OPERAND, AIT_F_STEP_DIRECT_8BIT_OPERAND, AIT_F_WORD_DIRECT_16BIT_OPERAND,
            AIT_F_BYTE_DIRECT_16BIT_OPERAND, AIT_F_BYTE_IND_DWORD};
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (400) rstep();
        $display("test random_mix finished");
        foreach (fl[i])
            for (int l = 0; l < 4; l++)
                for (int sm = 0; sm < 2; sm++)
                begin
                    o = (fl[i] == AIT_F_STEP_DIRECT_8BIT_OPERAND) ? AIT_OP_STEP_DOWN : AIT_OP_DIFF;
                    step(1'b1, o, fl[i], sizeOf(fl[i], 0), ait_loc_type'(l), sm, rnd() % 16,
                        rnd32(), rnd32(), 3'h1, 1'b0);
                end
        $display("test location_extras finished");
        for (int v = 0; v < 8; v++)
            step(1'b1, AIT_OP_STEP_UP, AIT_F_STEP_SHORT, ait_size_type'(v % 3), AIT_LOC_PLAIN,
                v % 2, 0, rnd32(), 0, v, 0);
        step(1'b1, AIT_OP_CARRY_SUM, AIT_F_ACC_IMM, AIT_SZ_BYTE, AIT_LOC_PLAIN, 0, 0,
            32'hff, 32'h0, 1, 1);
        step(1'b1, AIT_OP_BORROW_DIFF, AIT_F_ACC_BANK, AIT_SZ_BYTE, AIT_LOC_PLAIN, 1, 0,
            32'h0, 32'h0, 1, 1);
        step(1'b0, AIT_OP_SUM, AIT_F_ACC_BANK, AIT_SZ_BYTE, AIT_LOC_PLAIN, 0, 0, 0, 0, 1, 0);
        $display("test short_step_and_carry finished");
        // Asynchronous reset in mid-run clears every output
        @(posedge clk);
        rst_b <= 1'b0;
        pend = 1'b0;
        {eIll, eCy, eZ, eRes, eB, eSt, resK, lenK, flK} = {51'h0, 3'h7};
        step(1'b0, AIT_OP_SUM, AIT_F_ACC_BANK, AIT_SZ_BYTE, AIT_LOC_PLAIN, 0, 0, 0, 0, 1, 0);
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (40) rstep();
        step(1'b0, AIT_OP_SUM, AIT_F_ACC_BANK, AIT_SZ_BYTE, AIT_LOC_PLAIN, 0, 0, 0, 0, 1, 0);
        $display("test reset_restart finished");
        final_report();
    end
endmodule
